// File: include/sct_map.vh
// sct_map.vh: register offsets, field positions and reset values of the capture/compare timer
// assumes: included by the timer design files, 32-bit word-aligned register map
`ifndef SCT_MAP_VH
`define SCT_MAP_VH

// word-aligned byte offsets
`define SCT_OFS_SYSCTL 8'h00
`define SCT_OFS_DIRSEL 8'h04
`define SCT_OFS_PRESC 8'h08
`define SCT_OFS_COUNT 8'h0c
`define SCT_OFS_EDGE 8'h10
`define SCT_OFS_ACTION 8'h14
`define SCT_OFS_PACTL 8'h18
`define SCT_OFS_PACNT 8'h1c
`define SCT_OFS_STATUS 8'h20
`define SCT_OFS_MASK 8'h24
// channel value registers: base + 4 * channel
`define SCT_OFS_CHAN 8'h40

// timer_system_control_one fields
`define SCT_BIT_TEN 7
`define SCT_BIT_WSTOP 6
`define SCT_BIT_FSTOP 5

// pulse accumulator control fields
`define SCT_BIT_PAEN 0
`define SCT_BIT_PAMODE 1
`define SCT_BIT_PAPOL 2

// status and mask bit positions
`define SCT_BIT_TOF 8
`define SCT_BIT_PAIF 9
`define SCT_BIT_PAOVF 10
`define SCT_STAT_W 11

// channel count and implemented-channel mask
`define SCT_NCH 8
`define SCT_CH_IMPL 8'hff

// reset values
`define SCT_RST_SYSCTL 3'h0
`define SCT_RST_DIRSEL 8'h00
`define SCT_RST_PRESC 3'h0
`define SCT_RST_EDGE 16'h0000
`define SCT_RST_ACTION 16'h0000
`define SCT_RST_PACTL 3'h0
`define SCT_RST_MASK 11'h000

`endif

// File: hw/sct_sync.v
// sct_sync.v: two-stage synchroniser for a group of pin levels
// assumes: inputs are asynchronous to clk_sys_in; only stage two is read downstream
`timescale 1ns/1ps
module sct_sync (
  input wire clk_sys_in,
  input wire sys_rst_in,
  input wire [7:0] d_in,
  output reg [7:0] q_out
);
  reg [7:0] meta;

  // first stage feeds the second and nothing else
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      meta <= 8'h00;
      q_out <= 8'h00;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule

// File: hw/sct_chan.v
// sct_chan.v: one capture/compare channel with its value register and pin level
// assumes: pin_in already synchronised; tick_in marks a counter advance
`timescale 1ns/1ps
`include "sct_map.vh"
module sct_chan (
  input wire clk_sys_in,
  input wire sys_rst_in,
  input wire dir_in,
  input wire [1:0] edge_sel_in,
  input wire [1:0] action_in,
  input wire pin_in,
  input wire run_in,
  input wire tick_in,
  input wire [15:0] count_in,
  input wire wr_in,
  input wire [15:0] wdata_in,
  output reg [15:0] value_out,
  output reg event_out,
  output reg pin_out
);
  reg pin_prev;
  wire rise;
  wire fall;
  wire cap_hit;
  wire cmp_hit;

  // edge select: 01 rising, 10 falling, 11 either, 00 off
  assign rise = pin_in & ~pin_prev;
  assign fall = ~pin_in & pin_prev;
  assign cap_hit = ~dir_in & run_in & ((edge_sel_in[0] & rise) | (edge_sel_in[1] & fall));
  // compare fires once, on the advance that leaves the matching value
  assign cmp_hit = dir_in & tick_in & (count_in == value_out);

  // capture latches the count, compare drives the pin
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pin_prev <= 1'b0;
      value_out <= 16'h0000;
      event_out <= 1'b0;
      pin_out <= 1'b0;
    end else begin
      pin_prev <= pin_in;
      event_out <= cap_hit | cmp_hit; // [R3] [R4]
      if (cap_hit) begin
        value_out <= count_in; // [R3]
      end else if (wr_in) begin
        value_out <= wdata_in; // [R7]
      end
      if (cmp_hit) begin
        case (action_in)
          2'b01: pin_out <= ~pin_out; // [R4]
          2'b10: pin_out <= 1'b0;
          2'b11: pin_out <= 1'b1;
          default: pin_out <= pin_out; // software delay only
        endcase
      end
    end
  end
endmodule

// File: hw/sct_top.v
// sct_top.v: capture/compare timer with prescaled counter, eight channels, pulse accumulator
// assumes: AHB-Lite slave, single word transfers; mode inputs come from logic on clk_sys_in
// Function
// R1 - a 16-bit counter advances at a rate set by a software prescaler.
// R2 - eight identical channels, each usable as capture or compare.
// R3 - a capture channel latches the counter on the selected pin edge.
// R4 - a compare channel changes its pin or just flags when the counter matches.
// R5 - one 16-bit pulse accumulator counts events or gated time on channel 7.
// R6 - in event mode the accumulator uses the channel 7 pin input.
// R7 - counter and channel values move as one 16-bit word in a single access.
// R8 - in stop mode the whole timer is inactive.
// R9 - in freeze mode counting halts only if the freeze-stop bit is one.
// R10 - in wait mode counting halts only if the wait-stop bit is one.
// R11 - in normal mode the counter runs only while the timer enable bit is set.
// R12 - the channel 7 pin is capture input, compare output or accumulator input.
// R13 - pins 0 to 6 serve their channel as capture input or compare output.
// R14 - a direction select bit of 0 means capture and 1 means compare.
// R15 - select bits of absent channels ignore writes and read zero.
// R16 - the counter wraps from its maximum to zero and keeps counting.
//
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "sct_map.vh"
module sct_top (
  input wire clk_sys_in,
  input wire sys_rst_in,
  input wire hsel_in,
  input wire [7:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  output reg [31:0] hrdata_out,
  output reg hreadyout_out,
  output reg hresp_out,
  input wire stop_mode_in,
  input wire freeze_mode_in,
  input wire wait_mode_in,
  input wire [7:0] chan_pin_in,
  output reg [7:0] chan_pin_out,
  output reg [7:0] chan_pin_oe_n_out,
  output reg irq_out
);
  // software-visible state
  reg timer_enable_bit;
  reg wait_stop_bit;
  reg freeze_stop_bit;
  reg [7:0] channel_direction_select;
  reg [2:0] presc_sel;
  reg [15:0] count;
  reg [15:0] edge_cfg;
  reg [15:0] action_cfg;
  reg pa_enable;
  reg pa_gated;
  reg pa_polarity;
  reg [15:0] pa_count;
  reg [`SCT_STAT_W-1:0] status;
  reg [`SCT_STAT_W-1:0] mask;

  // internal state
  reg [6:0] presc_cnt;
  reg pa_prev;
  reg wr_pend;
  reg [7:0] wr_addr;

  // synchronised pins and per-channel results
  wire [7:0] pin_sync;
  wire [15:0] chan_value [0:7];
  wire [7:0] chan_event;
  wire [7:0] chan_level;

  // count gating, prescaler and counter
  wire stop_gate;
  wire freeze_gate;
  wire wait_gate;
  wire run_modes;
  wire run;
  reg presc_hit;
  wire tick;
  wire [16:0] next_count;
  wire tov_evt;

  // pulse accumulator
  wire pa_pin;
  wire pa_edge;
  wire pa_step;
  wire [16:0] next_pa_count;
  wire paov_evt;

  // bus decode, read data and status update
  wire [`SCT_STAT_W-1:0] events;
  wire addr_phase;
  wire do_wr;
  wire [7:0] chan_wr;
  reg [31:0] next_rdata;
  reg [`SCT_STAT_W-1:0] next_status;

  // one write strobe per control or status word
  wire wr_sysctl;
  wire wr_dirsel;
  wire wr_presc;
  wire wr_count;
  wire wr_edge;
  wire wr_action;
  wire wr_pactl;
  wire wr_pacnt;
  wire wr_status;
  wire wr_mask;

  // pins pass two flip-flops before any logic sees them
  sct_sync u_sync (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .d_in(chan_pin_in),
    .q_out(pin_sync)
  );

  // count gating across operating modes
  assign stop_gate = ~stop_mode_in; // [R8]
  assign freeze_gate = ~(freeze_mode_in & freeze_stop_bit); // [R9]
  assign wait_gate = ~(wait_mode_in & wait_stop_bit); // [R10]
  assign run_modes = stop_gate & freeze_gate & wait_gate;
  // normal mode also needs the enable bit
  assign run = run_modes & timer_enable_bit; // [R11]

  // prescaler: advance once every 2^presc_sel clocks
  always @* begin
    case (presc_sel)
      3'h0: presc_hit = 1'b1;
      3'h1: presc_hit = presc_cnt[0];
      3'h2: presc_hit = &presc_cnt[1:0];
      3'h3: presc_hit = &presc_cnt[2:0];
      3'h4: presc_hit = &presc_cnt[3:0];
      3'h5: presc_hit = &presc_cnt[4:0];
      3'h6: presc_hit = &presc_cnt[5:0];
      default: presc_hit = &presc_cnt[6:0];
    endcase
  end
  assign tick = run & presc_hit; // [R1]

  // free-running counter with natural wrap
  assign next_count = {1'b0, count} + 17'h00001;
  assign tov_evt = tick & next_count[16]; // [R16]

  // pulse accumulator shares the channel 7 pin
  assign pa_pin = pin_sync[7]; // [R6]
  assign pa_edge = pa_polarity ? (pa_pin & ~pa_prev) : (~pa_pin & pa_prev);
  // event mode counts edges, gated mode counts ticks while the pin is active
  assign pa_step = pa_enable & ~stop_mode_in
    & (pa_gated ? (tick & (pa_pin == pa_polarity)) : pa_edge); // [R5]
  assign next_pa_count = {1'b0, pa_count} + 17'h00001;
  assign paov_evt = pa_step & next_pa_count[16];

  // bus address phase and posted write decode
  assign addr_phase = hsel_in & htrans_in[1] & hready_in;
  assign do_wr = wr_pend;

  // a strobe is high in the data phase of a write to its word
  assign wr_sysctl = do_wr & (wr_addr == `SCT_OFS_SYSCTL);
  assign wr_dirsel = do_wr & (wr_addr == `SCT_OFS_DIRSEL);
  assign wr_presc = do_wr & (wr_addr == `SCT_OFS_PRESC);
  assign wr_count = do_wr & (wr_addr == `SCT_OFS_COUNT);
  assign wr_edge = do_wr & (wr_addr == `SCT_OFS_EDGE);
  assign wr_action = do_wr & (wr_addr == `SCT_OFS_ACTION);
  assign wr_pactl = do_wr & (wr_addr == `SCT_OFS_PACTL);
  assign wr_pacnt = do_wr & (wr_addr == `SCT_OFS_PACNT);
  assign wr_status = do_wr & (wr_addr == `SCT_OFS_STATUS);
  assign wr_mask = do_wr & (wr_addr == `SCT_OFS_MASK);

  // one channel instance per pin
  genvar gi;
  generate
    for (gi = 0; gi < `SCT_NCH; gi = gi + 1) begin : g_chan
      // word address of this channel's value register
      localparam [7:0] CHAN_OFS = `SCT_OFS_CHAN + 4 * gi;
      assign chan_wr[gi] = do_wr & (wr_addr == CHAN_OFS); // [R7]
      sct_chan u_chan (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .dir_in(channel_direction_select[gi]), // [R14]
        .edge_sel_in(edge_cfg[2*gi+1:2*gi]),
        .action_in(action_cfg[2*gi+1:2*gi]),
        .pin_in(pin_sync[gi]), // [R13]
        .run_in(run_modes), // [R8]
        .tick_in(tick),
        .count_in(count),
        .wr_in(chan_wr[gi]),
        .wdata_in(hwdata_in[15:0]),
        .value_out(chan_value[gi]),
        .event_out(chan_event[gi]),
        .pin_out(chan_level[gi])
      );
    end
  endgenerate

  // gather event sources for the sticky status bits
  assign events = {paov_evt, pa_step & ~pa_gated, tov_evt, chan_event & `SCT_CH_IMPL};

  // status: hardware set wins over write-one-to-clear
  always @* begin
    next_status = status;
    if (wr_status) begin
      next_status = status & ~hwdata_in[`SCT_STAT_W-1:0];
    end
    next_status = next_status | events;
  end

  // bus read mux, sampled at the end of the address phase
  always @* begin
    next_rdata = 32'h00000000;
    // channel value words sit above the control block
    if (haddr_in >= `SCT_OFS_CHAN && haddr_in < `SCT_OFS_CHAN + 8'h20) begin
      next_rdata = {16'h0000, chan_value[haddr_in[4:2]]}; // [R7]
    end else begin
      // control and status words, unmapped places read zero
      case (haddr_in)
        `SCT_OFS_SYSCTL: begin
          next_rdata[`SCT_BIT_TEN] = timer_enable_bit;
          next_rdata[`SCT_BIT_WSTOP] = wait_stop_bit;
          next_rdata[`SCT_BIT_FSTOP] = freeze_stop_bit;
        end
        `SCT_OFS_DIRSEL: next_rdata[7:0] = channel_direction_select & `SCT_CH_IMPL; // [R15]
        `SCT_OFS_PRESC: next_rdata[2:0] = presc_sel;
        `SCT_OFS_COUNT: next_rdata[15:0] = count; // [R7]
        `SCT_OFS_EDGE: next_rdata[15:0] = edge_cfg;
        `SCT_OFS_ACTION: next_rdata[15:0] = action_cfg;
        `SCT_OFS_PACTL: next_rdata[2:0] = {pa_polarity, pa_gated, pa_enable};
        `SCT_OFS_PACNT: next_rdata[15:0] = pa_count;
        `SCT_OFS_STATUS: next_rdata[`SCT_STAT_W-1:0] = status;
        `SCT_OFS_MASK: next_rdata[`SCT_STAT_W-1:0] = mask;
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      hrdata_out <= 32'h00000000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      // writes are posted: their data arrive one cycle after the address
      wr_pend <= addr_phase & hwrite_in;
      // reads load the word at the edge that takes the address
      if (addr_phase) begin
        wr_addr <= {haddr_in[7:2], 2'b00};
        if (!hwrite_in) begin
          hrdata_out <= next_rdata;
        end
      end
    end
  end

  // control registers written by software
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      {timer_enable_bit, wait_stop_bit, freeze_stop_bit} <= `SCT_RST_SYSCTL;
      channel_direction_select <= `SCT_RST_DIRSEL;
      presc_sel <= `SCT_RST_PRESC;
      edge_cfg <= `SCT_RST_EDGE;
      action_cfg <= `SCT_RST_ACTION;
      {pa_polarity, pa_gated, pa_enable} <= `SCT_RST_PACTL;
      mask <= `SCT_RST_MASK;
    end else begin
      // system control: enable and the two mode stop bits
      if (wr_sysctl) begin
        timer_enable_bit <= hwdata_in[`SCT_BIT_TEN]; // [R11]
        wait_stop_bit <= hwdata_in[`SCT_BIT_WSTOP]; // [R10]
        freeze_stop_bit <= hwdata_in[`SCT_BIT_FSTOP]; // [R9]
      end
      // only implemented channels take a direction bit
      if (wr_dirsel) begin
        channel_direction_select <= hwdata_in[7:0] & `SCT_CH_IMPL; // [R15] [R2]
      end
      if (wr_presc) begin
        presc_sel <= hwdata_in[2:0]; // [R1]
      end
      // two configuration bits per channel
      if (wr_edge) begin
        edge_cfg <= hwdata_in[15:0];
      end
      if (wr_action) begin
        action_cfg <= hwdata_in[15:0];
      end
      if (wr_pactl) begin
        pa_enable <= hwdata_in[`SCT_BIT_PAEN];
        pa_gated <= hwdata_in[`SCT_BIT_PAMODE];
        pa_polarity <= hwdata_in[`SCT_BIT_PAPOL];
      end
      if (wr_mask) begin
        mask <= hwdata_in[`SCT_STAT_W-1:0];
      end
    end
  end

  // prescaler, counter and accumulator; a bus write takes the whole word
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      presc_cnt <= 7'h00;
      count <= 16'h0000;
      pa_prev <= 1'b0;
      pa_count <= 16'h0000;
    end else begin
      pa_prev <= pa_pin;
      // prescaler moves only while the counter may run
      if (run) begin
        presc_cnt <= presc_cnt + 7'h01; // [R8]
      end
      // a counter write restarts the prescaler, so a full period follows
      if (wr_count) begin
        count <= hwdata_in[15:0]; // [R7]
        presc_cnt <= 7'h00;
      end else if (tick) begin
        count <= next_count[15:0]; // [R16]
      end
      // a software write beats an accumulator step in the same cycle
      if (wr_pacnt) begin
        pa_count <= hwdata_in[15:0];
      end else if (pa_step) begin
        pa_count <= next_pa_count[15:0]; // [R5]
      end
    end
  end

  // sticky status, interrupt and pin drivers
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      status <= {`SCT_STAT_W{1'b0}};
      irq_out <= 1'b0;
      chan_pin_out <= 8'h00;
      chan_pin_oe_n_out <= 8'hff;
    end else begin
      // irq uses the next status so it rises with the flag
      status <= next_status;
      irq_out <= |(next_status & mask);
      chan_pin_out <= chan_level & `SCT_CH_IMPL;
      // compare channels drive their pin except channel 7 in accumulator event mode; oe is low while driving
      chan_pin_oe_n_out <= ~(channel_direction_select & `SCT_CH_IMPL); // [R13]
      if (pa_enable && !pa_gated) begin
        chan_pin_oe_n_out[7] <= 1'b1; // [R12]
      end
    end
  end
endmodule

// File: dv/sct_asserts.sv
// sct_asserts.sv: port-level checks of the capture/compare timer
// assumes: bound into sct_top; one clock, synchronous active-high reset
`timescale 1ns/1ps
module sct_asserts (
  input wire clk_sys_in,
  input wire sys_rst_in,
  input wire hsel_in,
  input wire [7:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  input wire [31:0] hrdata_out,
  input wire hreadyout_out,
  input wire hresp_out,
  input wire stop_mode_in,
  input wire [7:0] chan_pin_out,
  input wire [7:0] chan_pin_oe_n_out
);
  reg dp_rd;
  reg dp_wr;
  reg [7:0] dp_addr;
  reg [7:0] dir_sh;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  // data phases on the bus and a shadow of the direction bits
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      {dp_rd, dp_wr, dp_addr, dir_sh} <= 18'h00000;
    end else begin
      if (dp_wr && dp_addr[7:2] == 6'h01) begin
        dir_sh <= hwdata_in[7:0];
      end
      dp_rd <= hsel_in && htrans_in[1] && hready_in && !hwrite_in;
      dp_wr <= hsel_in && htrans_in[1] && hready_in && hwrite_in;
      dp_addr <= haddr_in;
    end
  end
  // direction bits unchanged long enough for the enables to follow
  sequence dir_settled;
    $stable(dir_sh) [*3];
  endsequence
  chk_resp_okay: assert property (hresp_out == 1'b0)
    else $error("bus response not okay");
  chk_no_wait: assert property (hreadyout_out == 1'b1)
    else $error("wait state inserted");
  chk_read_width: assert property (dp_rd |-> hrdata_out[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  chk_dir_readback: assert property (dp_rd && dp_addr[7:2] == 6'h01 |-> hrdata_out[7:0] == dir_sh)
    else $error("direction readback differs");
  chk_low_drive: assert property (dir_settled |-> chan_pin_oe_n_out[6:0] == ~dir_sh[6:0])
    else $error("low channel enable wrong");
  chk_ch7_capture: assert property (dir_settled ##0 !dir_sh[7] |-> chan_pin_oe_n_out[7])
    else $error("channel 7 driven while capturing");
  chk_stop_pins: assert property (stop_mode_in [*4] |-> $stable(chan_pin_out))
    else $error("pin moved in stop mode");
  chk_pin_owner: assert property (((chan_pin_out ^ $past(chan_pin_out)) & chan_pin_oe_n_out) == 8'h00)
    else $error("undriven pin level changed");
endmodule
bind sct_top sct_asserts sct_asserts_inst (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel_in),
  .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
  .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .stop_mode_in(stop_mode_in),
  .chan_pin_out(chan_pin_out), .chan_pin_oe_n_out(chan_pin_oe_n_out));

// File: dv/sct_pin_model.sv
// sct_pin_model.sv: far side of the channel pins, sources and loads
// assumes: a low enable from the timer means the timer owns the wire
`timescale 1ns/1ps
module sct_pin_model (
  input wire [7:0] drive_in,
  input wire [7:0] drive_oe_n_in,
  input wire [7:0] src_in,
  output wire [7:0] level_out
);
  // driven pins carry the timer level, the rest the source level
  assign level_out = (drive_in & ~drive_oe_n_in) | (src_in & drive_oe_n_in);
endmodule

// File: dv/tb.sv
// tb.sv: self-checking bench for the capture/compare timer
// assumes: this bench is the only bus master; pins resolved by sct_pin_model
`timescale 1ns/1ps
`include "sct_map.vh"
module tb;
  localparam [31:0] EN = 32'h1 << `SCT_BIT_TEN;
  localparam [31:0] WS = 32'h1 << `SCT_BIT_WSTOP;
  localparam [31:0] FS = 32'h1 << `SCT_BIT_FSTOP;
  reg clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, stop = 1'b1;
  reg [1:0] htrans = 2'h0, fw = 2'h0, code;
  reg [7:0] haddr = 8'h00, src = 8'h00;
  reg [31:0] hwdata = 32'h0, edg = 32'h9e79, rdat;
  wire [31:0] hrdata;
  wire hready, irq;
  wire [7:0] drv, oe_n, lvl;
  integer n_fail = 0, comparisons = 0, i;
  // 20 MHz clock
  always #25 clk = ~clk;
  sct_top sct_top_inst (.clk_sys_in(clk), .sys_rst_in(rst), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(), .stop_mode_in(stop), .freeze_mode_in(fw[1]), .wait_mode_in(fw[0]),
    .chan_pin_in(lvl), .chan_pin_out(drv), .chan_pin_oe_n_out(oe_n), .irq_out(irq));
  sct_pin_model sct_pin_model_inst (.drive_in(drv), .drive_oe_n_in(oe_n), .src_in(src), .level_out(lvl));
  task report_and_stop;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // next rising edge with hready high, bounded
  task wait_ready;
    integer k;
    @(posedge clk);
    for (k = 0; k < 50 && hready !== 1'b1; k = k + 1) begin
      @(posedge clk);
    end
    if (k == 50) begin
      n_fail = n_fail + 1;
      report_and_stop;
    end
  endtask
  // one single-word transfer: address phase, then data phase
  task xfer(input w, input [7:0] a, input [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready;
    rdat = hrdata;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  // count n cycles from v with given control, prescale and modes
  task run(input [31:0] ctl, input [2:0] p, input [1:0] m, input [15:0] v, input integer n, input [15:0] e);
    stop <= 1'b1;
    wr(8'h00, ctl);
    wr(8'h08, {29'h0, p});
    wr(8'h0c, {16'h0, v});
    fw <= m;
    stop <= 1'b0;
    cyc(n);
    stop <= 1'b1;
    fw <= 2'h0;
    rd(8'h0c, {16'h0, e});
  endtask
  initial begin
    cyc(4);
    rst <= 1'b0;
    cyc(1);
    // reset value, unmapped place, direction readback
    rd(8'h00, 32'h0);
    wr(8'h30, 32'hffffffff);
    rd(8'h30, 32'h0);
    wr(8'h04, 32'h1a5);
    rd(8'h04, 32'ha5);
    cyc(2);
    chk(oe_n, 32'h5a);
    wr(8'h04, 32'h0);
    // counter gating by enable, modes and prescaler
    run(32'h0, 3'h0, 2'h0, 16'h1234, 5, 16'h1234);
    run(EN, 3'h0, 2'h0, 16'h0010, 5, 16'h0015);
    run(EN | FS, 3'h0, 2'h2, 16'h0020, 5, 16'h0020);
    run(EN | FS, 3'h0, 2'h1, 16'h0020, 5, 16'h0025);
    run(EN | WS, 3'h0, 2'h1, 16'h0030, 5, 16'h0030);
    run(EN, 3'h0, 2'h3, 16'h0030, 5, 16'h0035);
    run(EN, 3'h2, 2'h0, 16'h0040, 8, 16'h0042);
    run(EN, 3'h0, 2'h0, 16'hfffe, 5, 16'h0003);
    cyc(5);
    rd(8'h0c, 32'h3);
    // overflow flag, mask and clear
    rd(8'h20, 32'h100);
    wr(8'h24, 32'h100);
    cyc(2);
    chk(irq, 32'h1);
    wr(8'h20, 32'h100);
    cyc(2);
    chk(irq, 32'h0);
    // captures on every channel, edge codes rise, fall, both
    wr(8'h00, 32'h0);
    wr(8'h0c, 32'h4321);
    stop <= 1'b0;
    wr(8'h10, edg);
    for (i = 0; i < 8; i = i + 1) begin
      code = edg[2 * i +: 2];
      src[i] <= 1'b1;
      cyc(8);
      rd(8'h20, {31'h0, code[0]} << i);
      wr(8'h20, 32'h7ff);
      src[i] <= 1'b0;
      cyc(8);
      rd(8'h20, {31'h0, code[1]} << i);
      wr(8'h20, 32'h7ff);
      rd({i[5:0], 2'b00} + 8'h40, 32'h4321);
    end
    // compare actions toggle, clear, set, flag only on channels 0 to 3
    wr(8'h04, 32'hff);
    wr(8'h14, 32'h39);
    for (i = 0; i < 4; i = i + 1) begin
      wr({i[5:0], 2'b00} + 8'h40, 32'h100);
    end
    chk(oe_n, 32'h0);
    run(EN, 3'h0, 2'h0, 16'h00fe, 4, 16'h0102);
    cyc(4);
    chk(lvl[3:0], 32'h5);
    rd(8'h20, 32'hf);
    // accumulator counting rising edges on the shared channel 7 pin
    stop <= 1'b0;
    wr(8'h18, 32'h5);
    cyc(2);
    chk(oe_n[7], 32'h1);
    for (i = 0; i < 3; i = i + 1) begin
      src[7] <= 1'b1;
      cyc(4);
      src[7] <= 1'b0;
      cyc(4);
    end
    rd(8'h1c, 32'h3);
    rd(8'h20, 32'h20f);
    // gated accumulator counts ticks while channel 7 is high; channel 7 captures the fall
    wr(8'h04, 32'h7f);
    wr(8'h1c, 32'h0);
    wr(8'h18, 32'h7);
    wr(8'h20, 32'h7ff);
    src[7] <= 1'b1;
    cyc(10);
    src[7] <= 1'b0;
    cyc(6);
    rd(8'h1c, 32'ha);
    rd(8'h20, 32'h80);
    report_and_stop;
  end
endmodule
